// file: rtl/acc_ctrl.sv
// Converter control register, enable, soft reset and halts
`include "acc_defines.svh"
module acc_ctrl import acc_pkg::*; #(
	parameter int REC_CYCLES = `ACC_REC_CYCLES,
	parameter int DIS_CYCLES = `ACC_DIS_CYCLES,
	parameter int IDX_W = 6
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [11:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Converter side
	input wire logic trigger_i,
	input wire logic conv_done_i,
	input wire logic cmd_last_i,
	input wire logic severe_err_i,
	input wire logic freeze_mode_i,
	input wire logic wait_mode_i,
	output logic analog_en_o,
	output logic conv_start_o,
	output logic result_discard_o,
	output logic flags_clear_o,
	output logic [IDX_W-1:0] command_index_o,
	output logic [IDX_W-1:0] result_index_o,
	output logic command_list_select_o,
	output logic result_list_select_o,
	output logic irq_o
);
	//------------------------------------------------------------
	// Declarations
	//------------------------------------------------------------
	logic [15:0] ctl0; // Control register 0
	logic [`ACC_NIRQ-1:0] iflag; // Sticky event flags
	logic [`ACC_NIRQ-1:0] imask; // Interrupt enables
	acc_state_t state; // Sequencer state
	acc_state_t next_state; // Sequencer next state
	logic [IDX_W-1:0] cmd_idx; // Command position
	logic [IDX_W-1:0] res_idx; // Result position
	logic command_list_select; // Command list select
	logic result_list_select; // Result list select
	logic [1:0] sr_cnt; // Soft reset progress
	logic sr_busy; // Soft reset in progress
	logic dp_wr; // Write data phase pending
	logic [11:0] dp_addr; // Latched address
	logic tmr_load; // Start a timed period
	logic [15:0] tmr_count; // Period length
	logic tmr_done; // Timed period over
	logic trig_q; // Registered trigger
	logic conv_q; // Registered done
	logic sev_q; // Registered severe error
	logic frz_q; // Registered freeze
	logic wai_q; // Registered wait

	//------------------------------------------------------------
	// Bus decode
	//------------------------------------------------------------
	// Matches a live or latched address to one register word
	function automatic logic hit(input logic [11:0] a,
		input logic [11:0] ofs);
		hit = (a[11:2] == ofs[11:2]);
	endfunction

	wire addr_ph = hsel_i && htrans_i[1] && hready_i;
	wire wr_ctl = dp_wr && hit(dp_addr, `ACC_OFS_CTL0);
	wire wr_flag = dp_wr && hit(dp_addr, `ACC_OFS_IFLAG);
	wire wr_mask = dp_wr && hit(dp_addr, `ACC_OFS_IMASK);
	wire en = ctl0[`ACC_BIT_EN];
	// Gated fields open while disabled or special access
	wire cfg_open = !en || ctl0[`ACC_BIT_SMOD];
	wire [15:0] wmask = cfg_open ? `ACC_CTL0_WMASK : 16'hF000;
	wire want_en = wr_ctl && hwdata_i[`ACC_BIT_EN];
	wire en_fall = wr_ctl && en && !hwdata_i[`ACC_BIT_EN];
	// Re-enable refused while draining after a disable
	wire en_block = (state == ACC_DRAIN);
	wire sr_req = wr_ctl && hwdata_i[`ACC_BIT_SR];
	wire boundary = (state == ACC_CONVERT) && conv_q;
	wire halt_req = (ctl0[`ACC_BIT_FRZ] && frz_q) ||
		(ctl0[`ACC_BIT_WAI] && wai_q);

	// Read mux, decoded in the address phase
	wire [31:0] rd_ctl = {16'h0000, ctl0};
	wire [31:0] rd_stat = {8'h00, 2'b00, cmd_idx, 2'b00, res_idx,
		3'b000, result_list_select, command_list_select, state};
	wire [31:0] rd_data =
		hit(haddr_i, `ACC_OFS_CTL0) ? rd_ctl :
		hit(haddr_i, `ACC_OFS_STAT) ? rd_stat :
		hit(haddr_i, `ACC_OFS_IFLAG) ? {29'h0, iflag} :
		hit(haddr_i, `ACC_OFS_IMASK) ? {29'h0, imask} : 32'h0;

	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;

	//------------------------------------------------------------
	// Bus phase tracking
	//------------------------------------------------------------
	// Address phase captured for the following data phase
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dp_wr <= 1'b0;
			dp_addr <= 12'h000;
		end else begin
			dp_wr <= addr_ph && hwrite_i;
			dp_addr <= addr_ph ? haddr_i : dp_addr;
		end
	end

	// Read data registered so it stands in the data phase
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			hrdata_o <= 32'h0;
		end else if (addr_ph && !hwrite_i) begin
			hrdata_o <= rd_data;
		end
	end

	//------------------------------------------------------------
	// Converter inputs, registered once (same clock domain)
	//------------------------------------------------------------
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			trig_q <= 1'b0;
			conv_q <= 1'b0;
			sev_q <= 1'b0;
			frz_q <= 1'b0;
			wai_q <= 1'b0;
		end else begin
			trig_q <= trigger_i;
			conv_q <= conv_done_i;
			sev_q <= severe_err_i;
			frz_q <= freeze_mode_i;
			wai_q <= wait_mode_i;
		end
	end

	//------------------------------------------------------------
	// Control register 0
	//------------------------------------------------------------
	// Enable stays low while draining; soft reset self clears
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctl0 <= `ACC_CTL0_RESET;
		end else begin
			if (wr_ctl) begin
				ctl0[15:13] <= ctl0[15:13];
				ctl0[`ACC_BIT_FRZ] <= hwdata_i[`ACC_BIT_FRZ];
				ctl0[`ACC_BIT_WAI] <= hwdata_i[`ACC_BIT_WAI];
				ctl0[6:0] <= (hwdata_i[6:0] & wmask[6:0]) |
					(ctl0[6:0] & ~wmask[6:0]);
				ctl0[`ACC_BIT_EN] <= want_en && !en_block ? 1'b1 :
					(want_en ? en : 1'b0);
			end
			if (sr_req) begin
				ctl0[`ACC_BIT_SR] <= 1'b1;
			end else if (sr_busy && sr_cnt == 2'(`ACC_SR_CYCLES - 1)) begin
				ctl0[`ACC_BIT_SR] <= 1'b0;
			end
		end
	end

	assign sr_busy = ctl0[`ACC_BIT_SR];

	// Soft reset runs a fixed number of cycles
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sr_cnt <= 2'b00;
		end else if (!sr_busy || sr_req) begin
			sr_cnt <= 2'b00;
		end else begin
			sr_cnt <= sr_cnt + 2'b01;
		end
	end

	//------------------------------------------------------------
	// Sequencer
	//------------------------------------------------------------
	// Next state from enable, trigger, boundaries and errors
	always_comb begin
		next_state = state;
		tmr_load = 1'b0;
		tmr_count = 16'h0000;
		unique case (state)
			ACC_OFF: begin
				if (en) begin
					next_state = ACC_RECOVER;
					tmr_load = 1'b1;
					tmr_count = 16'(REC_CYCLES);
				end
			end
			ACC_DRAIN: begin
				if (tmr_done) begin
					next_state = ACC_OFF;
				end
			end
			ACC_RECOVER: begin
				if (tmr_done) begin
					next_state = ACC_IDLE;
				end
			end
			ACC_IDLE: begin
				if (trig_q && !halt_req) begin
					next_state = ACC_CONVERT;
				end
			end
			ACC_CONVERT: begin
				if (boundary && halt_req) begin
					next_state = ACC_HALTED;
				end else if (boundary && cmd_last_i) begin
					next_state = ACC_IDLE;
				end
			end
			ACC_HALTED: begin
				if (!halt_req) begin
					next_state = ACC_CONVERT;
				end
			end
			ACC_ERROR: begin
				next_state = ACC_ERROR;
			end
		endcase
		// Severe error stops everything until soft reset or disable
		if (sev_q && state != ACC_OFF && state != ACC_DRAIN) begin
			next_state = ACC_ERROR;
		end
		// Soft reset returns to idle; a converter still powering up
		// keeps its recovery; after a severe error during recovery a launch can skip it
		if (sr_busy && state != ACC_OFF && state != ACC_RECOVER &&
			state != ACC_DRAIN) begin
			next_state = ACC_IDLE;
		end
		// Disable aborts and drains
		if (en_fall) begin
			next_state = ACC_DRAIN;
			tmr_load = 1'b1;
			tmr_count = 16'(DIS_CYCLES);
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ACC_OFF;
		end else begin
			state <= next_state;
		end
	end

	acc_timer #(
		.WIDTH(16)
	) acc_timer_inst (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.load_i(tmr_load),
		.count_i(tmr_count),
		.done_o(tmr_done)
	);

	//------------------------------------------------------------
	// Command and result positions
	//------------------------------------------------------------
	// Indexes advance per conversion, held across halts
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmd_idx <= '0;
			res_idx <= '0;
			command_list_select <= 1'b0;
			result_list_select <= 1'b0;
		end else if (sr_busy) begin
			cmd_idx <= '0;
			res_idx <= '0;
			command_list_select <= 1'b0;
			result_list_select <= 1'b0;
		end else if (boundary && cmd_last_i) begin
			cmd_idx <= '0;
			res_idx <= '0;
			command_list_select <= ~command_list_select;
			result_list_select <= ~result_list_select;
		end else if (boundary) begin
			cmd_idx <= cmd_idx + 1'b1;
			res_idx <= res_idx + 1'b1;
		end
	end

	//------------------------------------------------------------
	// Outputs to the converter
	//------------------------------------------------------------
	assign analog_en_o = en;
	assign conv_start_o = (state == ACC_IDLE && next_state == ACC_CONVERT)
		|| (state == ACC_HALTED && next_state == ACC_CONVERT);
	assign result_discard_o = (state == ACC_DRAIN);
	assign flags_clear_o = sr_busy;
	assign command_index_o = cmd_idx;
	assign result_index_o = res_idx;
	assign command_list_select_o = command_list_select;
	assign result_list_select_o = result_list_select;

	//------------------------------------------------------------
	// Interrupts
	//------------------------------------------------------------
	wire [`ACC_NIRQ-1:0] ev;
	assign ev[`ACC_IRQ_SRDONE] = sr_busy &&
		sr_cnt == 2'(`ACC_SR_CYCLES - 1) && !sr_req;
	assign ev[`ACC_IRQ_READY] = state == ACC_RECOVER &&
		next_state == ACC_IDLE;
	assign ev[`ACC_IRQ_SEVERE] = state != ACC_ERROR &&
		next_state == ACC_ERROR;

	// Set wins over write-one-to-clear
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			iflag <= '0;
			imask <= '0;
		end else begin
			iflag <= ev | (iflag &
				~(wr_flag ? hwdata_i[`ACC_NIRQ-1:0] : '0));
			imask <= wr_mask ? hwdata_i[`ACC_NIRQ-1:0] : imask;
		end
	end

	assign irq_o = |(iflag & imask);

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	a_gated_cfg_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wr_ctl && en && !ctl0[`ACC_BIT_SMOD] |=> $stable(ctl0[6:0]))
		else $error("gated field changed while enabled");
	a_enable_power: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!analog_en_o |-> state == ACC_OFF || state == ACC_DRAIN)
		else $error("sequencer active while powered down");
	a_disable_drain: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		en_fall |=> state == ACC_DRAIN && result_discard_o)
		else $error("disable did not abort");
	a_no_reenable: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		state == ACC_DRAIN |=> !en)
		else $error("enabled during drain");
	a_recover_wait: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		state == ACC_RECOVER && next_state == ACC_IDLE |->
		$past(state, REC_CYCLES) == ACC_RECOVER)
		else $error("conversion launched without recovery");
	a_sr_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		sr_busy && !en_fall && state != ACC_OFF &&
		state != ACC_RECOVER && state != ACC_DRAIN |=> state == ACC_IDLE)
		else $error("soft reset did not idle");
	a_sr_index: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		sr_busy |=> cmd_idx == '0 && !command_list_select && !result_list_select)
		else $error("soft reset left indexes");
	a_sr_selfclr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		sr_req |=> sr_busy ##[1:3] !sr_busy || sr_req)
		else $error("soft reset bit did not self clear");
	a_severe_stop: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		state == ACC_ERROR && !sr_busy && !en_fall |=> state == ACC_ERROR)
		else $error("left error without soft reset");
	a_halt_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		state == ACC_HALTED && !sr_busy |=> $stable(cmd_idx))
		else $error("position lost during halt");
endmodule

// file: rtl/acc_defines.svh
// Constants for the converter control front end
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH

//------------------------------------------------------------
// Register offsets
//------------------------------------------------------------
`define ACC_OFS_CTL0 12'h000
`define ACC_OFS_STAT 12'h004
`define ACC_OFS_IFLAG 12'h008
`define ACC_OFS_IMASK 12'h00C

//------------------------------------------------------------
// Control register 0 fields
//------------------------------------------------------------
`define ACC_BIT_EN 15
`define ACC_BIT_SR 14
`define ACC_BIT_FRZ 13
`define ACC_BIT_WAI 12
`define ACC_BIT_SMOD 6
`define ACC_BIT_OPCFG 5
`define ACC_BIT_RSTAB 4
`define ACC_ACC_HI 1
`define ACC_ACC_LO 0
`define ACC_CTL0_RESET 16'h0000
`define ACC_CTL0_WMASK 16'hF073

//------------------------------------------------------------
// Interrupt flags: 0 soft reset done, 1 recovered, 2 severe
//------------------------------------------------------------
`define ACC_NIRQ 3
`define ACC_IRQ_SRDONE 0
`define ACC_IRQ_READY 1
`define ACC_IRQ_SEVERE 2

//------------------------------------------------------------
// Timing
//------------------------------------------------------------
`define ACC_CLK_PERIOD_NS 50
`define ACC_REC_TIME_NS 1000
`define ACC_REC_CYCLES ((`ACC_REC_TIME_NS + `ACC_CLK_PERIOD_NS - 1) / `ACC_CLK_PERIOD_NS)
`define ACC_DIS_TIME_NS 500
`define ACC_DIS_CYCLES (`ACC_DIS_TIME_NS / `ACC_CLK_PERIOD_NS)
`define ACC_SR_CYCLES 2

`endif

// file: rtl/acc_pkg.sv
// Types for the converter control front end
package acc_pkg;
	// Converter sequencer state
	typedef enum logic [2:0] {
		ACC_OFF,
		ACC_DRAIN,
		ACC_RECOVER,
		ACC_IDLE,
		ACC_CONVERT,
		ACC_HALTED,
		ACC_ERROR
	} acc_state_t;
endpackage

// file: rtl/acc_timer.sv
// Down counter for recovery and drain periods
module acc_timer import acc_pkg::*; #(
	parameter int WIDTH = 16
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic load_i,
	input wire logic [WIDTH-1:0] count_i,
	output logic done_o
);
	logic [WIDTH-1:0] count; // Cycles left

	//------------------------------------------------------------
	// Counter
	//------------------------------------------------------------
	// Load wins over the running count
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			count <= '0;
		end else if (load_i) begin
			count <= count_i;
		end else if (count != '0) begin
			count <= count - 1'b1;
		end
	end

	// Done once counted out, not in the load cycle
	assign done_o = (count == '0) && !load_i;
endmodule

// file: testbench/acc_ctrl_tb.sv
// Self-checking bench for the converter control front end
module acc_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int REC_N = 3;
	localparam int DIS_N = 3;
	// ----------------------------------------
	// Clock, reset and stimulus signals
	// ----------------------------------------
	logic clk = 1'b0, rst = 1'b1;
	logic hsel = 1'b0, hwrite = 1'b0, hready;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0, hrdata, q;
	logic trig = 1'b0, done = 1'b0, last = 1'b0, sev = 1'b0;
	logic frz = 1'b0, wai = 1'b0;
	logic aen, cstart, disc, fclr, csel, rsel, irq, hresp;
	logic [5:0] cidx, ridx;
	int num_errors = 0, checks_done = 0, cyc = 0, n_start = 0;
	int exp_idx = 0;
	always #25 clk = ~clk;
	acc_ctrl #(.REC_CYCLES(REC_N), .DIS_CYCLES(DIS_N)) acc_ctrl_inst (
		.sys_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
		.hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
		.hreadyout_o(hready), .hresp_o(hresp), .trigger_i(trig),
		.conv_done_i(done), .cmd_last_i(last), .severe_err_i(sev),
		.freeze_mode_i(frz), .wait_mode_i(wai), .analog_en_o(aen),
		.conv_start_o(cstart), .result_discard_o(disc),
		.flags_clear_o(fclr), .command_index_o(cidx),
		.result_index_o(ridx), .command_list_select_o(csel),
		.result_list_select_o(rsel), .irq_o(irq));
	// Cycle count for the hang limit, and launch pulse count
	always @(posedge clk) begin
		cyc++;
		if (cstart === 1'b1)
			n_start++;
		if (cyc == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic tally_and_finish();
		$display("errors=%0d checks=%0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One single-word transfer; address held until hready seen high
	task automatic bus(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		q = hrdata;
	endtask
	// Poll the state field under a bounded count
	task automatic wait_state(input logic [2:0] s);
		for (int i = 0; i < 40; i++) begin
			bus(1'b0, 12'h004, 32'h0);
			if (q[2:0] === s)
				break;
		end
		chk({29'h0, q[2:0]}, {29'h0, s});
	endtask
	task automatic pulse_done();
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		exp_idx++;
		@(posedge clk);
		@(posedge clk);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		bus(1'b0, 12'h000, 32'h0);
		chk(q, 32'h0);
		bus(1'b0, 12'h004, 32'h0);
		chk(q, 32'h0);
		chk({31'h0, irq}, 32'h0);
		chk({30'h0, hresp, aen}, 32'h0);
		$display("test reset done");
	endtask
	// Low fields open only while disabled or with special access
	task automatic t_gate();
		bus(1'b1, 12'h000, 32'h00000FFF);
		bus(1'b0, 12'h000, 32'h0);
		chk(q, 32'h00000073);
		bus(1'b1, 12'h000, 32'h00008040);
		bus(1'b1, 12'h000, 32'h00008071);
		bus(1'b0, 12'h000, 32'h0);
		chk(q, 32'h00008071);
		bus(1'b1, 12'h000, 32'h00008033);
		bus(1'b1, 12'h000, 32'h00008071);
		bus(1'b0, 12'h000, 32'h0);
		chk(q, 32'h00008033);
		chk({31'h0, aen}, 32'h1);
		$display("test gate done");
	endtask
	// Abort and refused re-enable, then recovery before launch
	task automatic t_dis_rec();
		trig <= 1'b1;
		wait_state(3'h4);
		bus(1'b1, 12'h000, 32'h0);
		@(posedge clk);
		chk({31'h0, disc}, 32'h1);
		bus(1'b1, 12'h000, 32'h00008000);
		bus(1'b0, 12'h000, 32'h0);
		chk({16'h0, q[15], 15'h0}, 32'h0);
		wait_state(3'h0);
		chk({31'h0, aen}, 32'h0);
		bus(1'b1, 12'h000, 32'h00008000);
		n_start = 0;
		repeat (REC_N + 2) @(posedge clk);
		chk(n_start, 32'h0);
		wait_state(3'h4);
		chk(n_start, 32'h1);
		$display("test disable and recovery done");
	endtask
	// Severe error halts; soft reset clears and reindexes
	task automatic t_err();
		pulse_done();
		chk({26'h0, cidx}, exp_idx);
		chk({26'h0, ridx}, exp_idx);
		last <= 1'b1;
		pulse_done();
		last <= 1'b0;
		exp_idx = 0;
		chk({30'h0, rsel, csel}, 32'h3);
		pulse_done();
		chk({26'h0, cidx}, exp_idx);
		bus(1'b1, 12'h00C, 32'h00000004);
		sev <= 1'b1;
		wait_state(3'h6);
		chk({31'h0, irq}, 32'h1);
		sev <= 1'b0;
		trig <= 1'b0;
		bus(1'b1, 12'h000, 32'h0000C000);
		@(posedge clk);
		chk({31'h0, fclr}, 32'h1);
		wait_state(3'h3);
		exp_idx = 0;
		bus(1'b0, 12'h000, 32'h0);
		chk(q, 32'h00008000);
		bus(1'b0, 12'h004, 32'h0);
		chk(q & 32'h003F3F18, 32'h0);
		bus(1'b0, 12'h008, 32'h0);
		chk(q & 32'h5, 32'h5);
		bus(1'b1, 12'h00C, 32'h0);
		bus(1'b1, 12'h008, 32'h00000007);
		chk({31'h0, irq}, 32'h0);
		bus(1'b0, 12'h008, 32'h0);
		chk(q, 32'h0);
		$display("test soft reset done");
	endtask
	// Freeze then wait halts at a boundary and resumes in place
	task automatic t_halt();
		trig <= 1'b1;
		wait_state(3'h4);
		frz <= 1'b1;
		pulse_done();
		wait_state(3'h4);
		frz <= 1'b0;
		for (int m = 0; m < 2; m++) begin
			bus(1'b1, 12'h000, m ? 32'h00009000 : 32'h0000A000);
			frz <= (m == 0);
			wai <= (m == 1);
			pulse_done();
			wait_state(3'h5);
			frz <= 1'b0;
			wai <= 1'b0;
			wait_state(3'h4);
			chk({26'h0, cidx}, exp_idx);
		end
		$display("test halt done");
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_gate();
		t_dis_rec();
		t_err();
		t_halt();
		tally_and_finish();
	end
endmodule
